// ### mpm_pkg.sv
package mpm_pkg;

  // ****************************************************************
  // Register map (byte addresses on the APB side).
  // ****************************************************************
  localparam logic [15:0] ADDR_MGMT_DATA    = 16'ha018;
  localparam logic [15:0] ADDR_MGMT_CONTROL = 16'ha01c;
  localparam logic [15:0] ADDR_CAM_ENABLE   = 16'ha028;
  localparam logic [15:0] ADDR_MISSED_COUNT = 16'ha03c;
  localparam logic [15:0] ADDR_PAUSE_COUNT  = 16'ha040;
  localparam logic [15:0] ADDR_ALIGN_COUNT  = 16'ha048;
  localparam logic [15:0] ADDR_CRC_COUNT    = 16'ha04c;

  // ****************************************************************
  // Reset values and field layout.
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET      = 32'h00008000;
  localparam int          CAM_MAX_ENTRIES = 21;
  localparam logic [15:0] MISSED_ROLL_LOW = 16'h7fff;

  // Management control word, bit 15 down to bit 0.
  typedef struct packed {
    logic [2:0] clk_div;
    logic       preamble_skip;
    logic       busy;
    logic       write;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
  } mpm_ctrl_t;

  // ****************************************************************
  // Management clock and frame timing.
  // ****************************************************************
  localparam int         MDC_BASE_PERIOD = 16;
  localparam logic [3:0] MDC_HALF_BASE   = 4'(MDC_BASE_PERIOD / 2);
  localparam logic [5:0] FRAME_START_IDX = 6'h20;
  localparam logic [5:0] FRAME_LAST_IDX  = 6'h3f;
  localparam logic [5:0] TURNAROUND_IDX  = 6'h2e;
  localparam logic [5:0] READ_DATA_IDX   = 6'h30;
  localparam logic [1:0] FRAME_START     = 2'h1;
  localparam logic [1:0] OPCODE_WRITE    = 2'h1;
  localparam logic [1:0] OPCODE_READ     = 2'h2;
  localparam logic [1:0] TA_WRITE        = 2'h2;

  typedef enum logic [1:0] {
    MG_IDLE,
    MG_XFER
  } mpm_mgmt_state_t;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic drop_overflow;
    logic drop_parity;
    logic drop_disabled;
    logic end_of_packet;
    logic align_err;
    logic crc_err;
  } mpm_rx_event_t;

  typedef struct packed {
    logic mdc;
    logic mdio_out;
    logic mdio_oe;
  } mpm_mdio_pins_t;

  typedef struct packed {
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    mpm_ctrl_t                  ctrl;
    logic [15:0]                mgmt_data;
    logic [CAM_MAX_ENTRIES-1:0] cam_en;
    logic [15:0]                missed;
    logic [15:0]                align_cnt;
    logic [15:0]                crc_cnt;
    logic [15:0]                pause_cnt;
    logic                       missed_flag;
    logic                       missed_irq;
    mpm_mgmt_state_t            mstate;
    logic [3:0]                 phase;
    logic [5:0]                 idx;
    logic [31:0]                shift;
    logic [15:0]                rdata;
    mpm_mdio_pins_t             pins;
    logic                       mdio_s1;
    logic                       mdio_s2;
  } mpm_state_t;

  localparam mpm_state_t STATE_RESET = '{
    ctrl:    mpm_ctrl_t'(CTRL_RESET[15:0]),
    mstate:  MG_IDLE,
    default: '0
  };

endpackage

// ### mpm_top.sv
// Local design decision: the APB register port.
`timescale 1ns/100ps
// Operation
// - A 16-bit data register carries write data and returned read data.
// - Management register contents steer only PHY transactions, nothing in MAC.
// - Control bits 4:0 hold the PHY register index sent each frame.
// - Control bits 9:5 hold the target PHY address.
// - Control bit 10 selects write when one, read when zero.
// - Software sets busy bit 11 to start; hardware clears it when done.
// - Control bit 12 set omits the preamble; clear sends it.
// - Management clock period is twice bits 15:13 plus 16 cycles.
// - Control register resets to 0x00008000, divider field 100.
// - Each of 21 enable bits enables the CAM entry of that index.
// - Enable bits above the highest implemented CAM entry are ignored.
// - Reading the missed counter returns its value and subtracts that value from it.
// - Missed counter stepping 0x7FFF to 0x8000 sets the flag, and the interrupt when enabled.
// - Software may write the missed counter, e.g. preload 0x7F00.
// - Missed count steps on overflow, parity or disabled drops only.
// - Alignment count steps at packet end when status shows alignment error.
// - CRC count steps only for a CRC error status.
// - A read-only 16-bit received pause counter resets to zero.
// - The pause counter counts slots the transmitter was held paused.
module mpm_top #(
  parameter int CAM_ENTRIES = 21
) (
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [15:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  // Receive events from the MAC, same clock.
  input  wire mpm_pkg::mpm_rx_event_t  rx_event,
  input  wire logic                    pause_slot,
  input  wire logic                    missed_flag_clear,
  input  wire logic                    missed_irq_enable,
  // CAM and missed-count outputs.
  output logic [CAM_ENTRIES-1:0]       cam_entry_enable_mask,
  output logic                         missed_rollover_flag,
  output logic                         missed_irq,
  // Management link pins.
  input  wire logic                    mdio_in,
  output mpm_pkg::mpm_mdio_pins_t      mdio_pins
);
  import mpm_pkg::*;

  mpm_state_t s;
  mpm_state_t next_s;

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Mask of the CAM enable bits that have an implemented entry.
  logic [CAM_MAX_ENTRIES-1:0] cam_impl;

  genvar gi;
  generate
    for (gi = 0; gi < CAM_MAX_ENTRIES; gi++) begin : g_cam
      assign cam_impl[gi] = (gi < CAM_ENTRIES);
    end
  endgenerate

  // Half period of the management clock for a divider setting.
  function automatic logic [3:0] mdc_half(input logic [2:0] div);
    mdc_half = MDC_HALF_BASE + {1'b0, div};
  endfunction

  // Decodes an address into the read value, or flags it as unmapped.
  function automatic logic [32:0] read_word(input logic [15:0] a,
                                            input mpm_state_t   st);
    read_word = {1'b0, 32'h0};
    case (a)
      ADDR_MGMT_DATA:    read_word = {17'h0, st.mgmt_data};
      ADDR_MGMT_CONTROL: read_word = {17'h0, st.ctrl};
      ADDR_CAM_ENABLE:   read_word = {12'h0, st.cam_en};
      ADDR_MISSED_COUNT: read_word = {17'h0, st.missed};
      ADDR_PAUSE_COUNT:  read_word = {17'h0, st.pause_cnt};
      ADDR_ALIGN_COUNT:  read_word = {17'h0, st.align_cnt};
      ADDR_CRC_COUNT:    read_word = {17'h0, st.crc_cnt};
      default:           read_word = {1'b1, 32'h0};
    endcase
  endfunction

  // Builds the 32 bits that follow the preamble.
  function automatic logic [31:0] frame_word(input mpm_ctrl_t   c,
                                             input logic [15:0] d);
    frame_word = {FRAME_START,
                  c.write ? OPCODE_WRITE : OPCODE_READ,
                  c.phy_addr,
                  c.reg_addr,
                  c.write ? TA_WRITE : 2'h0,
                  c.write ? d : 16'h0};
  endfunction

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  logic        access;
  logic        wr_acc;
  logic        rd_acc;
  logic [32:0] rd_sel;
  logic        drop;
  logic        rise;
  logic        fall;
  logic [5:0]  nidx;
  logic [31:0] nshift;

  // Computes the whole next state from the current one.
  always_comb begin
    next_s = s;
    access = psel && penable && s.pready;
    wr_acc = access && pwrite;
    rd_acc = access && !pwrite;
    rd_sel = read_word(paddr, s);
    drop   = rx_event.drop_overflow || rx_event.drop_parity
             || rx_event.drop_disabled;
    rise   = 1'b0;
    fall   = 1'b0;
    nidx   = s.idx + 6'h1;
    nshift = s.shift;

    // Input synchroniser for the data pin.
    next_s.mdio_s1 = mdio_in;
    next_s.mdio_s2 = s.mdio_s1;

    // APB: answer registered in the setup cycle, one-cycle access.
    next_s.pready  = psel && !penable;
    next_s.pslverr = 1'b0;
    next_s.prdata  = 32'h0;
    if (psel && !penable) begin
      next_s.pslverr = rd_sel[32];
      next_s.prdata  = pwrite ? 32'h0 : rd_sel[31:0];
    end

    // Received pause counter, read-only.
    if (pause_slot) begin
      next_s.pause_cnt = s.pause_cnt + 16'h1;
    end

    // Alignment and CRC error counters at packet end.
    if (rx_event.end_of_packet && rx_event.align_err) begin
      next_s.align_cnt = s.align_cnt + 16'h1;
    end
    if (rx_event.end_of_packet && rx_event.crc_err) begin
      next_s.crc_cnt = s.crc_cnt + 16'h1;
    end

    // Missed counter: drops counted, CAM rejects never reach here.
    if (drop) begin
      next_s.missed = s.missed + 16'h1;
    end
    if (rd_acc && paddr == ADDR_MISSED_COUNT) begin
      // Removes only what was reported, so a drop during the read stays.
      next_s.missed = s.missed + {15'h0, drop} - s.prdata[15:0];
    end
    if (wr_acc && paddr == ADDR_MISSED_COUNT) begin
      next_s.missed = pwdata[15:0];
    end

    // Rollover flag and interrupt; a new rollover wins over the clear.
    if (missed_flag_clear) begin
      next_s.missed_flag = 1'b0;
    end
    if (drop && s.missed == MISSED_ROLL_LOW
        && !(wr_acc && paddr == ADDR_MISSED_COUNT)) begin
      next_s.missed_flag = 1'b1;
    end
    next_s.missed_irq = next_s.missed_flag && missed_irq_enable;

    // CAM enable mask, unimplemented bits held at zero.
    if (wr_acc && paddr == ADDR_CAM_ENABLE) begin
      next_s.cam_en = pwdata[CAM_MAX_ENTRIES-1:0] & cam_impl;
    end

    // Management registers; ignored while a transaction runs.
    if (wr_acc && paddr == ADDR_MGMT_DATA && !s.ctrl.busy) begin
      next_s.mgmt_data = pwdata[15:0];
    end
    if (wr_acc && paddr == ADDR_MGMT_CONTROL && !s.ctrl.busy) begin
      next_s.ctrl = mpm_ctrl_t'(pwdata[15:0]);
    end

    // Management clock phase counter, only while a frame runs.
    if (s.mstate == MG_XFER) begin
      if (s.phase == mdc_half(s.ctrl.clk_div) - 4'h1) begin
        next_s.phase    = 4'h0;
        next_s.pins.mdc = !s.pins.mdc;
        rise            = !s.pins.mdc;
        fall            = s.pins.mdc;
      end else begin
        next_s.phase = s.phase + 4'h1;
      end
    end

    // Management transaction sequencer.
    case (s.mstate)
      MG_IDLE: begin
        next_s.pins = '0;
        if (s.ctrl.busy) begin
          next_s.mstate       = MG_XFER;
          next_s.phase        = 4'h0;
          next_s.shift        = frame_word(s.ctrl, s.mgmt_data);
          next_s.idx          = s.ctrl.preamble_skip
                                ? FRAME_START_IDX : 6'h0;
          next_s.pins.mdio_oe = 1'b1;
          next_s.pins.mdio_out = s.ctrl.preamble_skip
                                 ? next_s.shift[31] : 1'b1;
        end
      end
      MG_XFER: begin
        // Sample returned data on the rising management clock edge.
        if (rise && !s.ctrl.write && s.idx >= READ_DATA_IDX) begin
          next_s.rdata = {s.rdata[14:0], s.mdio_s2};
        end
        if (fall) begin
          if (s.idx == FRAME_LAST_IDX) begin
            next_s.mstate       = MG_IDLE;
            next_s.pins.mdio_oe = 1'b0;
            next_s.pins.mdio_out = 1'b0;
            if (!s.ctrl.write) begin
              next_s.mgmt_data = s.rdata;
            end
            next_s.ctrl.busy = 1'b0;
          end else begin
            if (nidx > FRAME_START_IDX) begin
              nshift = {s.shift[30:0], 1'b0};
            end
            next_s.idx   = nidx;
            next_s.shift = nshift;
            next_s.pins.mdio_out = (nidx < FRAME_START_IDX)
                                   ? 1'b1 : nshift[31];
            // Release the pin for turnaround and data on reads.
            next_s.pins.mdio_oe = s.ctrl.write
                                  || nidx < TURNAROUND_IDX;
          end
        end
      end
      default: begin
        next_s.mstate = MG_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Registers the whole block state.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register.
  // ****************************************************************

  // The management fields drive only the link pins, never the MAC.
  assign mdio_pins             = s.pins;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign prdata                = s.prdata;
  assign cam_entry_enable_mask = s.cam_en[CAM_ENTRIES-1:0];
  assign missed_rollover_flag  = s.missed_flag;
  assign missed_irq            = s.missed_irq;

endmodule

// ### mpm_phy_model.sv
`timescale 1ns/100ps
// ****
// Management link partner.
// ****
module mpm_phy_model (
  // Clock and capture clear.
  input  wire logic                   core_clk,
  input  wire logic                   clr,
  // Link pins and read reply word.
  input  wire mpm_pkg::mpm_mdio_pins_t pins,
  input  wire logic [15:0]            rd_word,
  // Drive and capture results.
  output logic                        drv,
  output logic                        val,
  output logic [63:0]                 rx,
  output int                          nbits
);
  import mpm_pkg::*;
  logic mdc_q = 1'b0;
  int   k     = 18;
  initial begin
    drv   = 1'b0;
    val   = 1'b1;
    rx    = '0;
    nbits = 0;
  end
  // Samples on mdc rise; replies after turnaround, changing on mdc fall.
  always @(negedge core_clk) begin
    mdc_q <= pins.mdc;
    if (clr) begin
      rx    <= '0;
      nbits <= 0;
    end else if (pins.mdc && !mdc_q && pins.mdio_oe) begin
      rx    <= {rx[62:0], pins.mdio_out};
      nbits <= nbits + 1;
    end
    if (pins.mdio_oe) begin
      k <= 0;
    end else if (!pins.mdc && mdc_q) begin
      drv <= (k >= 1 && k <= 17);
      val <= (k >= 2 && k <= 17) ? rd_word[17-k] : 1'b0;
      k   <= k + 1;
    end
  end
endmodule

// ### mpm_top_assertions.sv
`timescale 1ns/100ps
// ****
// Port checker.
// ****
module mpm_top_assertions #(
  parameter int CAM_ENTRIES = 21
) (
  // Clock, reset and APB.
  input wire logic                    core_clk,
  input wire logic                    resetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [15:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  // Events and outputs.
  input wire mpm_pkg::mpm_rx_event_t  rx_event,
  input wire logic                    missed_flag_clear,
  input wire logic                    missed_irq_enable,
  input wire logic [CAM_ENTRIES-1:0]  cam_entry_enable_mask,
  input wire logic                    missed_rollover_flag,
  input wire logic                    missed_irq,
  input wire mpm_pkg::mpm_mdio_pins_t mdio_pins
);
  import mpm_pkg::*;
  logic drop;
  // Any of the three drop reasons.
  assign drop = rx_event.drop_overflow | rx_event.drop_parity
              | rx_event.drop_disabled;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cam_wr;
    psel && penable && pready && pwrite && paddr == ADDR_CAM_ENABLE;
  endsequence
  AST_PREADY_ONE: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready is not one access cycle");
  AST_CAM_WRITE: assert property (s_cam_wr |=>
    cam_entry_enable_mask == $past(pwdata[CAM_ENTRIES-1:0]))
    else $error("cam mask not loaded");
  AST_CAM_HOLD: assert property ((!psel || !penable || !pready
    || !pwrite || paddr != ADDR_CAM_ENABLE) |=>
    $stable(cam_entry_enable_mask)) else $error("cam mask moved");
  AST_IRQ: assert property (1 |=> missed_irq ==
    (missed_rollover_flag && $past(missed_irq_enable)))
    else $error("irq not flag and enable");
  AST_FLAG_STICKY: assert property (missed_rollover_flag &&
    !missed_flag_clear |=> missed_rollover_flag) else $error("flag lost");
  AST_FLAG_CAUSE: assert property ($rose(missed_rollover_flag) |->
    $past(drop)) else $error("flag set without a drop");
  AST_MDC_HIGH: assert property ($rose(mdio_pins.mdc) |->
    mdio_pins.mdc [*8] ##[1:8] !mdio_pins.mdc)
    else $error("mdc high half wrong");
  AST_MDC_LOW: assert property ($fell(mdio_pins.mdc) |->
    !mdio_pins.mdc [*8]) else $error("mdc low half short");
  AST_OUT_EDGE: assert property ($changed(mdio_pins.mdio_out) &&
    $past(mdio_pins.mdio_oe) && mdio_pins.mdio_oe |-> $fell(mdio_pins.mdc))
    else $error("mdio changed off the mdc fall");
endmodule
bind mpm_top mpm_top_assertions #(.CAM_ENTRIES(CAM_ENTRIES)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .rx_event(rx_event), .missed_flag_clear(missed_flag_clear),
  .missed_irq_enable(missed_irq_enable), .missed_irq(missed_irq),
  .cam_entry_enable_mask(cam_entry_enable_mask),
  .missed_rollover_flag(missed_rollover_flag), .mdio_pins(mdio_pins));

// ### mpm_top_tb.sv
`timescale 1ns/100ps
// ****
// Register-level bench.
// ****
module mpm_top_tb;
  import mpm_pkg::*;
  logic           core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic           pause_slot, missed_flag_clear, missed_irq_enable, clr;
  logic           missed_rollover_flag, missed_irq, mdio_in, drv, val, e;
  logic           mdc_q;
  logic [15:0]    paddr, cam_entry_enable_mask;
  logic [31:0]    pwdata, prdata, q;
  logic [63:0]    rx;
  logic [5:0]     evs [9] = '{6'h20, 6'h10, 6'h08, 6'h38, 6'h04, 6'h06,
                              6'h05, 6'h02, 6'h06};
  mpm_rx_event_t  rx_event;
  mpm_mdio_pins_t mdio_pins;
  int             fails = 0, checks = 0, per = 0, cnt = 0, nbits;
  mpm_top #(.CAM_ENTRIES(16)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .rx_event(rx_event), .pause_slot(pause_slot),
    .missed_flag_clear(missed_flag_clear),
    .missed_irq_enable(missed_irq_enable),
    .cam_entry_enable_mask(cam_entry_enable_mask),
    .missed_rollover_flag(missed_rollover_flag), .missed_irq(missed_irq),
    .mdio_in(mdio_in), .mdio_pins(mdio_pins));
  mpm_phy_model i_phy (.core_clk(core_clk), .clr(clr), .pins(mdio_pins),
    .rd_word(16'h3c96), .drv(drv), .val(val), .rx(rx), .nbits(nbits));
  // Wire level from both drivers, pull-up when released.
  assign mdio_in = mdio_pins.mdio_oe ? mdio_pins.mdio_out : (drv ? val : 1'b1);
  // Clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Measures the mdc period between rising edges.
  always @(negedge core_clk) begin
    mdc_q <= mdio_pins.mdc;
    if (mdio_pins.mdc && !mdc_q) begin
      per <= cnt;
      cnt <= 1;
    end else cnt <= cnt + 1;
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // One APB transfer; waits for pready, then releases.
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Looks at pready as sampled at each rising edge, then takes prdata and pslverr once it is high.
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task ev(input logic [5:0] v, input logic p);
    @(posedge core_clk);
    {rx_event, pause_slot} <= {v, p};
    @(posedge core_clk);
    {rx_event, pause_slot} <= 7'h00;
    #1;
  endtask
  // Runs one management frame and polls busy down.
  task frame(input logic [31:0] c);
    int n;
    @(posedge core_clk) clr <= 1'b1;
    @(posedge core_clk) clr <= 1'b0;
    apb(1'b1, ADDR_MGMT_CONTROL, c);
    apb(1'b1, ADDR_MGMT_DATA, 32'h0);
    n = 0;
    do begin
      apb(1'b0, ADDR_MGMT_CONTROL, 32'h0);
      n++;
    end while (q[11] !== 1'b0 && n < 1000);
  endtask
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog.
  initial begin
    #500000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
  // Test sequence.
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_event, pause_slot, missed_flag_clear, missed_irq_enable, clr} = '0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ADDR_MGMT_CONTROL, 32'h00008000);
    rd(ADDR_PAUSE_COUNT, 32'h0);
    rd(ADDR_MISSED_COUNT, 32'h0);
    rd(16'ha100, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, ADDR_PAUSE_COUNT, 32'h1234);
    apb(1'b1, ADDR_CAM_ENABLE, 32'hffffffff);
    chk(cam_entry_enable_mask, 32'hffff);
    rd(ADDR_CAM_ENABLE, 32'h0000ffff);
    apb(1'b1, ADDR_CAM_ENABLE, 32'h0000a5c3);
    chk(cam_entry_enable_mask, 32'ha5c3);
    for (int i = 0; i < 9; i++) ev(evs[i], i < 3);
    rd(ADDR_MISSED_COUNT, 32'h4);
    rd(ADDR_MISSED_COUNT, 32'h0);
    rd(ADDR_ALIGN_COUNT, 32'h2);
    rd(ADDR_CRC_COUNT, 32'h1);
    rd(ADDR_PAUSE_COUNT, 32'h3);
    apb(1'b1, ADDR_MISSED_COUNT, 32'h7f00);
    repeat (255) ev(6'h20, 1'b0);
    chk(missed_rollover_flag, 32'h0);
    ev(6'h20, 1'b0);
    chk(missed_rollover_flag, 32'h1);
    chk(missed_irq, 32'h0);
    @(posedge core_clk) missed_irq_enable <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(missed_irq, 32'h1);
    rd(ADDR_MISSED_COUNT, 32'h8000);
    @(posedge core_clk) missed_flag_clear <= 1'b1;
    @(posedge core_clk) missed_flag_clear <= 1'b0;
    apb(1'b1, ADDR_MGMT_DATA, 32'ha5c3);
    frame(32'h00000e2a);
    chk(q, 32'h0000062a);
    chk(missed_rollover_flag, 32'h0);
    chk(rx[63:32], 32'hffffffff);
    chk(rx[31:0], {4'h5, 5'h11, 5'h0a, 2'b10, 16'ha5c3});
    chk(nbits, 32'd64);
    chk(per, 32'd16);
    rd(ADDR_MGMT_DATA, 32'ha5c3);
    frame(32'h0000f87f);
    chk(q, 32'h0000f07f);
    chk(nbits, 32'd14);
    chk(rx[13:0], {4'h6, 5'h03, 5'h1f});
    chk(per, 32'd30);
    rd(ADDR_MGMT_DATA, 32'h3c96);
    stop_test;
  end
endmodule
